/* File: rtl/nib_exec_pkg.sv */
// package: constants, opcodes, register map and carrier types for the nibble executor
package nib_exec_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int INSTR_W = 16;
	localparam int NIB_W = 4;
	localparam int MADDR_W = 7;
	localparam int PC_W = 11;
	localparam int BUS_AW = 8;
	localparam int BUS_DW = 16;
	localparam int MEM_WORDS = 128;

	// ****************************************
	// instruction encodings
	// ****************************************
	localparam logic [15:0] OPC_FORCE_CARRY = 16'h5040;  // whole word
	localparam logic [11:0] OPC_WRITE_PMF = 12'h160;     // word bits 15:4
	localparam logic [8:0] OPC_SHL_ZERO = 9'h098;        // word bits 15:7
	localparam logic [8:0] OPC_SHR_ZERO = 9'h09a;
	localparam logic [8:0] OPC_SKIP_BIT0 = 9'h110;
	localparam logic [8:0] OPC_SKIP_BIT1 = 9'h111;

	// ****************************************
	// field positions and program counter steps
	// ****************************************
	localparam int PMF_WDT_BIT = 3;    // immediate bit that picks the slow watchdog clock
	localparam int FLAG_CARRY_BIT = 0;
	localparam int FLAG_ZERO_BIT = 1;
	localparam logic [PC_W-1:0] PC_STEP = 11'h001;
	localparam logic [PC_W-1:0] PC_SKIP = 11'h002;

	// ****************************************
	// register map (addresses below 8'h80 reach the data memory)
	// ****************************************
	localparam logic [BUS_AW-1:0] REG_FLAGS = 8'h80;
	localparam logic [BUS_AW-1:0] REG_ACC = 8'h81;
	localparam logic [BUS_AW-1:0] REG_PMF = 8'h82;
	localparam logic [BUS_AW-1:0] REG_PC = 8'h83;
	localparam int MEM_SEL_BIT = 7;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [PC_W-1:0] RST_PC = 11'h000;
	localparam logic [NIB_W-1:0] RST_ACC = 4'h0;
	localparam logic RST_CARRY = 1'b0;
	localparam logic RST_ZERO = 1'b0;
	localparam logic RST_WDT_SEL = 1'b0;

	// ****************************************
	// carrier types
	// ****************************************
	typedef enum logic [2:0] {
		OP_OTHER,
		OP_FORCE_CARRY,
		OP_WRITE_PMF,
		OP_SHL_ZERO,
		OP_SHR_ZERO,
		OP_SKIP_BIT0,
		OP_SKIP_BIT1
	} op_e;

	typedef struct packed {
		op_e op;
		logic [MADDR_W-1:0] addr;
		logic [NIB_W-1:0] imm;
	} dec_s;

	typedef struct packed {
		logic [NIB_W-1:0] value;
		logic carry;
		logic zero;
		logic skip;
	} exec_res_s;

	typedef struct packed {
		logic we;
		logic [MADDR_W-1:0] addr;
		logic [NIB_W-1:0] data;
	} mem_wr_s;

endpackage

/* File: rtl/nib_instr_decode.sv */
// instruction decoder and shift / skip datapath for one fetched word
`timescale 1ns/100ps

module nib_instr_decode
	import nib_exec_pkg::*;
(
	input wire logic [nib_exec_pkg::INSTR_W-1:0] i_instr,
	input wire logic [nib_exec_pkg::NIB_W-1:0] i_operand,
	output nib_exec_pkg::dec_s o_dec,
	output nib_exec_pkg::exec_res_s o_res
);
	import nib_exec_pkg::*;

	// opcode match; anything not listed falls to OP_OTHER
	function automatic op_e decode_op(input logic [INSTR_W-1:0] w);
		op_e op;
		op = OP_OTHER;
		if (w == OPC_FORCE_CARRY)
			op = OP_FORCE_CARRY;
		else if (w[15:4] == OPC_WRITE_PMF)
			op = OP_WRITE_PMF;
		else if (w[15:7] == OPC_SHL_ZERO)
			op = OP_SHL_ZERO;
		else if (w[15:7] == OPC_SHR_ZERO)
			op = OP_SHR_ZERO;
		else if (w[15:7] == OPC_SKIP_BIT0)
			op = OP_SKIP_BIT0;
		else if (w[15:7] == OPC_SKIP_BIT1)
			op = OP_SKIP_BIT1;
		return op;
	endfunction

	wire op_e op_w = decode_op(i_instr);
	wire logic [NIB_W-1:0] shl_w = {i_operand[2:0], 1'b0};
	wire logic [NIB_W-1:0] shr_w = {1'b0, i_operand[3:1]};
	wire logic is_left_w = (op_w == OP_SHL_ZERO);
	wire logic [NIB_W-1:0] shifted_w = is_left_w ? shl_w : shr_w;

	// operand address comes straight from the low seven instruction bits
	assign o_dec.op = op_w;
	assign o_dec.addr = i_instr[MADDR_W-1:0];
	assign o_dec.imm = i_instr[NIB_W-1:0];

	// results: the carry takes the bit that falls off the end
	assign o_res.value = shifted_w;
	assign o_res.carry = is_left_w ? i_operand[3] : i_operand[0];
	assign o_res.zero = (shifted_w == 4'h0);
	assign o_res.skip = ((op_w == OP_SKIP_BIT0) && i_operand[0])
		|| ((op_w == OP_SKIP_BIT1) && i_operand[1]);

endmodule

/* File: rtl/nib_data_ram.sv */
// data memory of nibbles: one write port, two asynchronous read ports
`timescale 1ns/100ps

module nib_data_ram
	import nib_exec_pkg::*;
#(
	parameter int WORDS = nib_exec_pkg::MEM_WORDS
)
(
	input wire logic i_clk,
	input wire nib_exec_pkg::mem_wr_s i_wr,
	input wire logic [nib_exec_pkg::MADDR_W-1:0] i_raddr_a,
	input wire logic [nib_exec_pkg::MADDR_W-1:0] i_raddr_b,
	output logic [nib_exec_pkg::NIB_W-1:0] o_rdata_a,
	output logic [nib_exec_pkg::NIB_W-1:0] o_rdata_b
);
	import nib_exec_pkg::*;

	logic [NIB_W-1:0] mem [WORDS];

	// contents are not reset: the core clears memory in software if it needs to
	always_ff @(posedge i_clk)
	begin
		if (i_wr.we)
			mem[i_wr.addr] <= i_wr.data;
	end

	// port a feeds the executing instruction, port b the register bus
	assign o_rdata_a = mem[i_raddr_a];
	assign o_rdata_b = mem[i_raddr_b];

endmodule

/* File: rtl/nib_exec_core.sv */
// executor for carry set, parameter flag write, zero-fill shifts and bit skips
`timescale 1ns/100ps

// Summary of operation
// - force carry to one, other flags untouched
// - immediate bit 3 selects slow watchdog clock
// - left shift, old bit 3 to carry
// - right shift, old bit 0 to carry
// - shift operand addressed by instruction bits 6:0
// - bit 0 set skips, program counter plus two
// - bit 1 set skips, program counter plus two
module nib_exec_core
	import nib_exec_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_exec,
	input wire logic [nib_exec_pkg::INSTR_W-1:0] i_instr,
	input wire logic [nib_exec_pkg::BUS_AW-1:0] i_addr,
	input wire logic [nib_exec_pkg::BUS_DW-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [nib_exec_pkg::BUS_DW-1:0] o_rdata,
	output logic o_carry_flag,
	output logic o_zero_flag,
	output logic [nib_exec_pkg::NIB_W-1:0] o_accumulator_nibble,
	output logic [nib_exec_pkg::PC_W-1:0] o_program_counter,
	output logic o_wdt_slow_clk_sel,
	output logic o_exec_done,
	output logic o_unknown_instr
);
	import nib_exec_pkg::*;

	// ****************************************
	// state
	// ****************************************
	logic carry_r;
	logic zero_r;
	logic [NIB_W-1:0] acc_r;
	logic [PC_W-1:0] pc_r;
	logic wdt_sel_r;
	logic done_r;
	logic unknown_r;
	logic [BUS_DW-1:0] rdata_r;

	logic carry_nxt;
	logic zero_nxt;
	logic [NIB_W-1:0] acc_nxt;
	logic [PC_W-1:0] pc_nxt;
	logic wdt_sel_nxt;
	logic [BUS_DW-1:0] rdata_nxt;

	dec_s dec;
	exec_res_s res;
	mem_wr_s mem_wr;
	logic [NIB_W-1:0] operand;
	logic [NIB_W-1:0] bus_mem_rdata;

	// ****************************************
	// decode and datapath
	// ****************************************
	nib_instr_decode u_decode
	(
		.i_instr(i_instr),
		.i_operand(operand),
		.o_dec(dec),
		.o_res(res)
	);

	nib_data_ram #(
		.WORDS(MEM_WORDS)
	) u_ram
	(
		.i_clk(i_clk),
		.i_wr(mem_wr),
		.i_raddr_a(dec.addr),
		.i_raddr_b(i_addr[MADDR_W-1:0]),
		.o_rdata_a(operand),
		.o_rdata_b(bus_mem_rdata)
	);

	// ****************************************
	// strobes
	// ****************************************
	wire logic do_setc = i_exec && (dec.op == OP_FORCE_CARRY);
	wire logic do_pmf = i_exec && (dec.op == OP_WRITE_PMF);
	wire logic do_shift = i_exec && ((dec.op == OP_SHL_ZERO) || (dec.op == OP_SHR_ZERO));
	wire logic do_skip = i_exec && ((dec.op == OP_SKIP_BIT0) || (dec.op == OP_SKIP_BIT1));
	wire logic do_other = i_exec && (dec.op == OP_OTHER);

	// bus side decode; the memory region is the lower half of the map
	wire logic bus_is_mem = !i_addr[MEM_SEL_BIT];
	wire logic wr_flags = i_wr && (i_addr == REG_FLAGS);
	wire logic wr_acc = i_wr && (i_addr == REG_ACC);
	wire logic wr_pmf = i_wr && (i_addr == REG_PMF);
	wire logic wr_pc = i_wr && (i_addr == REG_PC);
	wire logic wr_mem = i_wr && bus_is_mem;

	// ****************************************
	// next-state selection
	// ****************************************
	// an executing instruction wins over a bus write in the same cycle,
	// so software never silently undoes a flag the core just produced
	assign carry_nxt = do_setc ? 1'b1 :
		do_shift ? res.carry :
		wr_flags ? i_wdata[FLAG_CARRY_BIT] : carry_r;
	assign zero_nxt = do_shift ? res.zero :
		wr_flags ? i_wdata[FLAG_ZERO_BIT] : zero_r;
	assign acc_nxt = do_shift ? res.value :
		wr_acc ? i_wdata[NIB_W-1:0] : acc_r;
	// reserved immediate bits 2:0 are simply not stored
	assign wdt_sel_nxt = do_pmf ? dec.imm[PMF_WDT_BIT] :
		wr_pmf ? i_wdata[PMF_WDT_BIT] : wdt_sel_r;
	// every instruction advances by one; a taken skip by two
	assign pc_nxt = i_exec ? (pc_r + (res.skip ? PC_SKIP : PC_STEP)) :
		wr_pc ? i_wdata[PC_W-1:0] : pc_r;

	// memory write: shift result back to the addressed nibble, else the bus
	assign mem_wr.we = do_shift || wr_mem;
	assign mem_wr.addr = do_shift ? dec.addr : i_addr[MADDR_W-1:0];
	assign mem_wr.data = do_shift ? res.value : i_wdata[NIB_W-1:0];

	// read mux; reserved and unmapped bits read as zero
	assign rdata_nxt = bus_is_mem ? {12'h000, bus_mem_rdata} :
		(i_addr == REG_FLAGS) ? {14'h0000, zero_r, carry_r} :
		(i_addr == REG_ACC) ? {12'h000, acc_r} :
		(i_addr == REG_PMF) ? {12'h000, wdt_sel_r, 3'h0} :
		(i_addr == REG_PC) ? {5'h00, pc_r} : 16'h0000;

	// ****************************************
	// registers
	// ****************************************
	// architectural state, updated by executed instructions and by bus writes
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			carry_r <= RST_CARRY;
			zero_r <= RST_ZERO;
			acc_r <= RST_ACC;
			pc_r <= RST_PC;
			wdt_sel_r <= RST_WDT_SEL;
		end
		else
		begin
			carry_r <= carry_nxt;
			zero_r <= zero_nxt;
			acc_r <= acc_nxt;
			pc_r <= pc_nxt;
			wdt_sel_r <= wdt_sel_nxt;
		end
	end

	// completion pulse and bus read data, each valid for one cycle
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			done_r <= 1'b0;
			unknown_r <= 1'b0;
			rdata_r <= 16'h0000;
		end
		else
		begin
			done_r <= i_exec;
			unknown_r <= do_other;
			rdata_r <= i_rd ? rdata_nxt : 16'h0000;
		end
	end

	assign o_rdata = rdata_r;
	assign o_carry_flag = carry_r;
	assign o_zero_flag = zero_r;
	assign o_accumulator_nibble = acc_r;
	assign o_program_counter = pc_r;
	assign o_wdt_slow_clk_sel = wdt_sel_r;
	assign o_exec_done = done_r;
	assign o_unknown_instr = unknown_r;

	// ****************************************
	// assertions
	// ****************************************
	a_setc_carry_high: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		do_setc |=> carry_r)
		else $error("carry not forced high");

	a_setc_zero_kept: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(do_setc && !wr_flags && !wr_acc) |=>
			(zero_r == $past(zero_r)) && (acc_r == $past(acc_r)))
		else $error("force carry disturbed other state");

	a_pmf_wdt_select: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		do_pmf |=> (wdt_sel_r == $past(i_instr[PMF_WDT_BIT])))
		else $error("watchdog clock select not taken from immediate bit 3");

	a_shl_result: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_exec && dec.op == OP_SHL_ZERO) |=>
			(acc_r == {$past(operand[2:0]), 1'b0}) && (carry_r == $past(operand[3])))
		else $error("left shift result or carry wrong");

	a_shr_result: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_exec && dec.op == OP_SHR_ZERO) |=>
			(acc_r == {1'b0, $past(operand[3:1])}) && (carry_r == $past(operand[0])))
		else $error("right shift result or carry wrong");

	a_shift_mem_addr: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		do_shift |-> mem_wr.we && (mem_wr.addr == i_instr[6:0]) && (mem_wr.data == res.value))
		else $error("shift result not written to the addressed nibble");

	a_skip_bit0: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_exec && dec.op == OP_SKIP_BIT0) |=>
			(pc_r == PC_W'($past(pc_r) + ($past(operand[0]) ? 11'd2 : 11'd1))))
		else $error("bit 0 skip advanced the counter wrongly");

	a_skip_bit1: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_exec && dec.op == OP_SKIP_BIT1) |=>
			(pc_r == PC_W'($past(pc_r) + ($past(operand[1]) ? 11'd2 : 11'd1))))
		else $error("bit 1 skip advanced the counter wrongly");

	a_shift_zero_flag: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		do_shift |=> o_exec_done && (zero_r == (acc_r == 4'h0)))
		else $error("zero flag or completion wrong after shift");

	// side effects: an instruction leaves alone whatever it does not name
	a_setc_wdt_kept: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(do_setc && !wr_pmf) |=> (wdt_sel_r == $past(wdt_sel_r)))
		else $error("force carry disturbed the parameter flags");

	a_setc_mem_kept: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		do_setc |-> (mem_wr.we == wr_mem))
		else $error("force carry wrote the data memory");

	a_pmf_reserved_zero: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_rd && (i_addr == REG_PMF)) |=> (o_rdata == {12'h000, $past(wdt_sel_r), 3'h0}))
		else $error("reserved parameter bits did not read as zero");

	a_pmf_flags_kept: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(do_pmf && !wr_flags && !wr_acc) |=>
			(carry_r == $past(carry_r)) && (zero_r == $past(zero_r)) &&
			(acc_r == $past(acc_r)))
		else $error("parameter flag write disturbed carry, zero or accumulator");

	a_shl_mem_data: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_exec && (dec.op == OP_SHL_ZERO)) |->
			mem_wr.we && (mem_wr.data == {operand[2:0], 1'b0}))
		else $error("left shift result not stored to memory");

	a_shr_mem_data: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_exec && (dec.op == OP_SHR_ZERO)) |->
			mem_wr.we && (mem_wr.data == {1'b0, operand[3:1]}))
		else $error("right shift result not stored to memory");

	a_shift_no_skip: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		do_shift |=> (pc_r == PC_W'($past(pc_r) + 11'd1)))
		else $error("shift did not step the counter by one");

	a_skip_state_kept: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(do_skip && !i_wr) |=>
			(carry_r == $past(carry_r)) && (zero_r == $past(zero_r)) &&
			(acc_r == $past(acc_r)))
		else $error("skip disturbed carry, zero or accumulator");

	a_skip_mem_kept: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		do_skip |-> (mem_wr.we == wr_mem))
		else $error("skip wrote the data memory");

	// timing: one cycle per instruction, pulses only when earned
	a_flag_ops_step: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(do_setc || do_pmf || do_other) |=> (pc_r == PC_W'($past(pc_r) + 11'd1)))
		else $error("non-skip instruction did not step the counter by one");

	a_exec_done_high: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		i_exec |=> o_exec_done)
		else $error("instruction took more than one cycle");

	a_exec_done_low: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		!i_exec |=> !o_exec_done)
		else $error("completion pulse without an instruction");

	a_unknown_pulse: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		do_other |=> o_unknown_instr)
		else $error("undecoded word not flagged");

	a_unknown_quiet: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		!do_other |=> !o_unknown_instr)
		else $error("decoded instruction flagged as unknown");

endmodule

/* File: bench/shift_skip_flag_instr_exec_bench.sv */
// self-checking bench for the nibble executor: integer model compared after every instruction
`timescale 1ns/100ps

`define CHK(got, exp) \
	begin \
		total_checks++; \
		if ((got) !== (exp)) \
		begin \
			n_fail++; \
			$display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
		end \
	end

module shift_skip_flag_instr_exec_bench;
	import nib_exec_pkg::*;

	// ****************************************
	// design ports and model state
	// ****************************************
	logic i_clk, i_rst_n, i_exec, i_wr, i_rd;
	logic [15:0] i_instr, i_wdata, o_rdata, w, d;
	logic [7:0] i_addr;
	logic o_carry_flag, o_zero_flag, o_wdt_slow_clk_sel, o_exec_done, o_unknown_instr;
	logic [3:0] o_accumulator_nibble;
	logic [10:0] o_program_counter;
	logic [6:0] a;
	logic [15:0] seed;
	int n_fail, total_checks, op, v, res, skip;
	int mem[128];
	int carry, zero, acc, pc, wdt;

	nib_exec_core DUT (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_exec(i_exec), .i_instr(i_instr),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_carry_flag(o_carry_flag), .o_zero_flag(o_zero_flag),
		.o_accumulator_nibble(o_accumulator_nibble), .o_program_counter(o_program_counter),
		.o_wdt_slow_clk_sel(o_wdt_slow_clk_sel), .o_exec_done(o_exec_done),
		.o_unknown_instr(o_unknown_instr)
	);

	// free-running core clock
	always #5 i_clk = ~i_clk;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task wrap_up;
		$display("checks=%0d mismatches=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// one-cycle write strobe; the slave never stalls
	task bus_wr(input logic [7:0] ad, input logic [15:0] dt);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= ad;
		i_wdata <= dt;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe, so sample there
	task bus_rd(input logic [7:0] ad, output logic [15:0] dt);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= ad;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		dt = o_rdata;
	endtask

	// one execute pulse; state is settled just after the following edge
	task exec(input logic [15:0] iw);
		@(posedge i_clk);
		i_exec <= 1'b1;
		i_instr <= iw;
		@(posedge i_clk);
		i_exec <= 1'b0;
		#1;
	endtask

	task check_state;
		`CHK(o_carry_flag, carry[0])
		`CHK(o_zero_flag, zero[0])
		`CHK(o_accumulator_nibble, acc[3:0])
		`CHK(o_program_counter, pc[10:0])
		`CHK(o_wdt_slow_clk_sel, wdt[0])
		`CHK(o_exec_done, 1'b1)
	endtask

	// every output reads zero straight after a reset
	task check_reset;
		`CHK(o_carry_flag, 1'b0)
		`CHK(o_zero_flag, 1'b0)
		`CHK(o_accumulator_nibble, 4'h0)
		`CHK(o_program_counter, 11'h000)
		`CHK(o_wdt_slow_clk_sel, 1'b0)
		`CHK(o_exec_done, 1'b0)
		`CHK(o_unknown_instr, 1'b0)
		`CHK(o_rdata, 16'h0000)
	endtask

	// hang guard: a run far beyond its expected length counts as a mismatch
	initial
	begin
		#200000;
		n_fail++;
		wrap_up();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		i_clk = 0;
		i_rst_n = 0;
		i_exec = 0;
		i_wr = 0;
		i_rd = 0;
		i_instr = 16'h0000;
		i_wdata = 16'h0000;
		i_addr = 8'h00;
		seed = 16'h0005;
		n_fail = 0;
		total_checks = 0;
		carry = 0;
		zero = 0;
		acc = 0;
		pc = 0;
		wdt = 0;
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		#1;
		check_reset();
		// every instruction against every operand nibble, random address and flags
		for (int k = 0; k < 96; k++)
		begin
			op = k % 6;
			v = k / 6;
			skip = 0;
			seed = lfsr_next(seed);
			a = seed[6:0];
			bus_wr({1'b0, a}, 16'(v));
			mem[a] = v;
			bus_wr(REG_FLAGS, {14'h0000, seed[9:8]});
			carry = seed[8];
			zero = seed[9];
			case (op)
				0:
				begin
					w = OPC_FORCE_CARRY;
					carry = 1;
				end
				1:
				begin
					w = {OPC_WRITE_PMF, seed[13:10]};
					wdt = seed[13];
				end
				2:
				begin
					w = {OPC_SHL_ZERO, a};
					carry = (v >> 3) & 1;
					res = (v << 1) & 15;
				end
				3:
				begin
					w = {OPC_SHR_ZERO, a};
					carry = v & 1;
					res = v >> 1;
				end
				4:
				begin
					w = {OPC_SKIP_BIT0, a};
					skip = v & 1;
				end
				default:
				begin
					w = {OPC_SKIP_BIT1, a};
					skip = (v >> 1) & 1;
				end
			endcase
			if (op == 2 || op == 3)
			begin
				acc = res;
				mem[a] = res;
				zero = (res == 0);
			end
			pc = (pc + (skip ? 2 : 1)) & 'h7ff;
			exec(w);
			check_state();
			`CHK(o_unknown_instr, 1'b0)
			bus_rd({1'b0, a}, d);
			`CHK(d, 16'(mem[a]))
		end
		// an undecoded word only steps the counter
		exec(16'h0000);
		pc = (pc + 1) & 'h7ff;
		`CHK(o_unknown_instr, 1'b1)
		`CHK(o_program_counter, pc[10:0])
		bus_rd(REG_PMF, d);
		`CHK(d, 16'(wdt << 3))
		bus_rd(8'h90, d);
		`CHK(d, 16'h0000)
		// registers read back over the bus; read data fall to zero a cycle later
		bus_rd(REG_FLAGS, d);
		`CHK(d, 16'(zero * 2 + carry))
		bus_rd(REG_ACC, d);
		`CHK(d, 16'(acc))
		bus_rd(REG_PC, d);
		`CHK(d, 16'(pc))
		@(posedge i_clk);
		#1;
		`CHK(o_rdata, 16'h0000)
		`CHK(o_exec_done, 1'b0)
		// a taken skip from the top of the counter wraps round to one
		bus_wr(REG_PC, 16'h07ff);
		bus_wr({1'b0, a}, 16'h0003);
		mem[a] = 3;
		pc = 1;
		exec({OPC_SKIP_BIT1, a});
		check_state();
		// reset again mid-run: state returns to zero, then execution resumes
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		#1;
		carry = 0;
		zero = 0;
		acc = 0;
		pc = 0;
		wdt = 0;
		check_reset();
		exec(OPC_FORCE_CARRY);
		carry = 1;
		pc = 1;
		check_state();
		wrap_up();
	end
endmodule
